// File: logic/sd_decim_pkg.sv
// Purpose: Shared constants and types for the sigma-delta decimation chain
// Assumes: One system clock at 100 MHz, which also serves as master clock
// Notes:   Word width is fixed here so the stage carrier type can be shared
package sd_decim_pkg;

  // Data path widths
  localparam int WORD_W   = 24;
  localparam int GROW_W   = 5;  // Head room for a sum of up to 32 words
  localparam int CNT_W    = 5;  // Counts up to 32 inputs per output
  localparam int LOG2_W   = 3;
  localparam int SETTLE_W = 15;

  // Stage ratios as powers of two
  localparam logic [LOG2_W-1:0] LOG2_STAGE1   = 3'h2; // 4x
  localparam logic [LOG2_W-1:0] LOG2_STAGE2_A = 3'h3; // 8x for 64 overall
  localparam logic [LOG2_W-1:0] LOG2_STAGE2_B = 3'h4; // 16x for 128 overall
  localparam logic [LOG2_W-1:0] LOG2_STAGE2_C = 3'h5; // 32x for 256 overall
  localparam logic [LOG2_W-1:0] LOG2_STAGE3   = 3'h1; // 2x

  // Internal sample clock divider: last count of each period
  localparam logic [1:0] DIV_MAX_NORMAL = 2'h1; // Master clock / 2
  localparam logic [1:0] DIV_MAX_LOW    = 2'h3; // Master clock / 4

  // Sync restart to settled, in master clock periods (7122, 14217, 27895)
  localparam logic [SETTLE_W-1:0] SETTLE_64_DEF  = 15'h1bd2;
  localparam logic [SETTLE_W-1:0] SETTLE_128_DEF = 15'h3789;
  localparam logic [SETTLE_W-1:0] SETTLE_256_DEF = 15'h6cf7;

  // Pin levels
  localparam logic SYNC_IDLE = 1'b1;

  // Nominal delays at 20 MHz sample clock and 64x, in system cycles
  localparam real CLK_PERIOD_NS    = 10.0;
  localparam real COMP_DELAY_US    = 2.25;
  localparam real FILTER_DELAY_US  = 87.6;
  localparam int  COMP_DELAY_CYC   = int'(COMP_DELAY_US * 1000.0 / CLK_PERIOD_NS);
  localparam int  FILTER_DELAY_CYC = int'(FILTER_DELAY_US * 1000.0 / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    DEC_64  = 2'b00,
    DEC_128 = 2'b01,
    DEC_256 = 2'b10
  } dec_mode_type;

  typedef struct packed {
    logic                     valid;
    logic signed [WORD_W-1:0] data;
  } stage_word_type;

endpackage

// File: logic/sd_decim_chain.sv
// Purpose: Three-stage decimating FIR chain behind a sigma-delta modulator
// Assumes: Modulator words arrive on CLK_SYS; SYNC_N and mode pins are asynchronous
// Notes:   Each stage is an all-ones FIR that sums and dumps, scaled back to 24 bits
`timescale 1ns/1ps
`default_nettype none

// One decimating FIR stage with a run-time power-of-two ratio
module decim_stage (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              clr,
  input  wire logic [sd_decim_pkg::LOG2_W-1:0]   log2_ratio,
  input  wire sd_decim_pkg::stage_word_type      in_word,
  output var  sd_decim_pkg::stage_word_type      out_word
);
  import sd_decim_pkg::*;
  localparam int AW = WORD_W + GROW_W;

  logic signed [AW-1:0] acc_ff;
  logic signed [AW-1:0] nxt_acc;
  logic [CNT_W-1:0]     cnt_ff;
  logic [CNT_W-1:0]     nxt_cnt;
  stage_word_type       out_ff;
  stage_word_type       nxt_out;
  logic [CNT_W:0]       ratio_full;
  logic [CNT_W-1:0]     last_cnt;
  logic signed [AW-1:0] sum;
  logic signed [AW-1:0] scaled;

  // Sum inputs, dump a scaled word after the last one of each group
  always_comb begin
    ratio_full = (CNT_W+1)'(1) << log2_ratio;
    last_cnt   = ratio_full[CNT_W-1:0] - CNT_W'(1);
    sum        = acc_ff + {{GROW_W{in_word.data[WORD_W-1]}}, in_word.data};
    scaled     = sum >>> log2_ratio;
    nxt_acc    = acc_ff;
    nxt_cnt    = cnt_ff;
    nxt_out    = '0;
    if (clr) begin
      nxt_acc = '0;
      nxt_cnt = '0;
    end else if (in_word.valid) begin
      if (cnt_ff == last_cnt) begin
        nxt_out.valid = 1'b1;
        nxt_out.data  = scaled[WORD_W-1:0];
        nxt_acc       = '0;
        nxt_cnt       = '0;
      end else begin
        nxt_acc = sum;
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= '0;
      cnt_ff <= '0;
      out_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign out_word = out_ff;
endmodule

// What this block does
// - Take one modulator word on every internal sample clock cycle.
// - Output word rate is sample rate divided by 64 or more.
// - Three FIR stages in series, each feeding the next.
// - First stage decimates the sample stream by four.
// - Second stage decimates by eight, sixteen or thirty-two as selected.
// - Third stage always decimates by two.
// - Overall ratios are exactly 64, 128 and 256.
// - Normal power: internal sample clock is master clock divided by two.
// - Low power: internal sample clock is master clock divided by four.
// - Settled flag rises 7122, 14217 or 27895 master clocks after restart.
// - Group delay is computation delay plus filter delay.
// - Stop band spans half output rate to sample rate minus that.
// - Falling sync edge restarts all filter state.
// - Decimation select pins choose 64, 128 or 256.
// - Low reset input clears all filter circuitry and holds it idle.
module sd_decim_chain #(
  parameter logic [sd_decim_pkg::SETTLE_W-1:0] SETTLE_64  = sd_decim_pkg::SETTLE_64_DEF,
  parameter logic [sd_decim_pkg::SETTLE_W-1:0] SETTLE_128 = sd_decim_pkg::SETTLE_128_DEF,
  parameter logic [sd_decim_pkg::SETTLE_W-1:0] SETTLE_256 = sd_decim_pkg::SETTLE_256_DEF
) (
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST_N,
  input  wire logic                             SYNC_N,
  input  wire logic [1:0]                       DECIMATION_SELECT,
  input  wire logic                             LOW_POWER,
  input  wire logic [sd_decim_pkg::WORD_W-1:0]  MOD_WORD,
  output logic                                  INTERNAL_SAMPLE_TICK,
  output logic [sd_decim_pkg::WORD_W-1:0]       OUT_WORD,
  output logic                                  OUT_VALID,
  output logic                                  FILTER_SETTLED_FLAG
);
  import sd_decim_pkg::*;

  logic                sync_meta_ff, sync_pin_ff, sync_prev_ff;
  logic [1:0]          dec_meta_ff, dec_pin_ff;
  logic                lp_meta_ff, lp_pin_ff;
  logic                start_ff, nxt_start;
  logic                restart_ff, nxt_restart;
  dec_mode_type        dec_mode_ff, nxt_dec_mode;
  logic [1:0]          div_ff, nxt_div;
  logic                tick_ff, nxt_tick;
  logic                lp_mode_ff, nxt_lp_mode;
  logic [1:0]          div_max;
  logic [LOG2_W-1:0]   log2_stage2;
  logic [SETTLE_W-1:0] settle_target;
  logic [SETTLE_W-1:0] settle_cnt_ff, nxt_settle_cnt;
  logic                settled_ff, nxt_settled;
  logic [WORD_W-1:0]   out_word_ff, nxt_out_word;
  logic                out_valid_ff, nxt_out_valid;
  stage_word_type      s0, s1, s2, s3;

  // Three flip-flops on the sync pin (two synchronize, one finds the edge); idle level in reset avoids a false edge
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sync_meta_ff <= SYNC_IDLE;
      sync_pin_ff  <= SYNC_IDLE;
      sync_prev_ff <= SYNC_IDLE;
    end else begin
      sync_meta_ff <= SYNC_N;
      sync_pin_ff  <= sync_meta_ff;
      sync_prev_ff <= sync_pin_ff;
    end
  end

  // Mode pins keep sampling in reset so the release restart sees real levels
  always_ff @(posedge CLK_SYS) begin
    dec_meta_ff <= DECIMATION_SELECT;
    dec_pin_ff  <= dec_meta_ff;
    lp_meta_ff  <= LOW_POWER;
    lp_pin_ff   <= lp_meta_ff;
  end

  // Restart after reset release or a falling sync edge; mode latched then
  always_comb begin
    nxt_start    = 1'b0;
    nxt_restart  = start_ff || (sync_prev_ff && !sync_pin_ff);
    nxt_dec_mode = dec_mode_ff;
    if (restart_ff) begin
      unique case (dec_pin_ff)
        2'b01:   nxt_dec_mode = DEC_128;
        2'b10:   nxt_dec_mode = DEC_256;
        default: nxt_dec_mode = DEC_64;
      endcase
    end
  end

  // Sample clock divider; power mode taken at each period boundary
  always_comb begin
    div_max     = lp_mode_ff ? DIV_MAX_LOW : DIV_MAX_NORMAL;
    nxt_div     = div_ff + 2'h1;
    nxt_tick    = 1'b0;
    nxt_lp_mode = lp_mode_ff;
    if (restart_ff) begin
      nxt_div     = 2'h0;
      nxt_lp_mode = lp_pin_ff;
    end else if (div_ff == div_max) begin
      nxt_div     = 2'h0;
      nxt_tick    = 1'b1;
      nxt_lp_mode = lp_pin_ff;
    end
  end

  // Settle counter and output register
  always_comb begin
    unique case (dec_mode_ff)
      DEC_128: begin
        log2_stage2   = LOG2_STAGE2_B;
        settle_target = SETTLE_128;
      end
      DEC_256: begin
        log2_stage2   = LOG2_STAGE2_C;
        settle_target = SETTLE_256;
      end
      default: begin
        log2_stage2   = LOG2_STAGE2_A;
        settle_target = SETTLE_64;
      end
    endcase
    nxt_settle_cnt = settle_cnt_ff;
    nxt_settled    = settled_ff;
    if (restart_ff) begin
      nxt_settle_cnt = '0;
      nxt_settled    = 1'b0;
    end else if (!settled_ff) begin
      if (settle_cnt_ff == settle_target - SETTLE_W'(1)) begin
        nxt_settled = 1'b1;
      end else begin
        nxt_settle_cnt = settle_cnt_ff + SETTLE_W'(1);
      end
    end
    nxt_out_valid = s3.valid && settled_ff && !restart_ff;
    nxt_out_word  = s3.valid ? s3.data : out_word_ff;
  end

  // Control registers; low reset clears all of them except start_ff, which it sets to force a restart
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      start_ff      <= 1'b1;
      restart_ff    <= 1'b0;
      dec_mode_ff   <= DEC_64;
      div_ff        <= 2'h0;
      tick_ff       <= 1'b0;
      lp_mode_ff    <= 1'b0;
      settle_cnt_ff <= '0;
      settled_ff    <= 1'b0;
      out_word_ff   <= '0;
      out_valid_ff  <= 1'b0;
    end else begin
      start_ff      <= nxt_start;
      restart_ff    <= nxt_restart;
      dec_mode_ff   <= nxt_dec_mode;
      div_ff        <= nxt_div;
      tick_ff       <= nxt_tick;
      lp_mode_ff    <= nxt_lp_mode;
      settle_cnt_ff <= nxt_settle_cnt;
      settled_ff    <= nxt_settled;
      out_word_ff   <= nxt_out_word;
      out_valid_ff  <= nxt_out_valid;
    end
  end

  // One modulator word per sample tick enters the chain
  always_comb begin
    s0.valid = tick_ff;
    s0.data  = MOD_WORD;
  end

  // Three stages in series; delays and stop band follow from the FIR taps
  decim_stage stage1 (.clk(CLK_SYS), .rst_n(RST_N), .clr(restart_ff),
    .log2_ratio(LOG2_STAGE1), .in_word(s0), .out_word(s1));
  decim_stage stage2 (.clk(CLK_SYS), .rst_n(RST_N), .clr(restart_ff),
    .log2_ratio(log2_stage2), .in_word(s1), .out_word(s2));
  decim_stage stage3 (.clk(CLK_SYS), .rst_n(RST_N), .clr(restart_ff),
    .log2_ratio(LOG2_STAGE3), .in_word(s2), .out_word(s3));

  assign INTERNAL_SAMPLE_TICK = tick_ff;
  assign OUT_WORD             = out_word_ff;
  assign OUT_VALID            = out_valid_ff;
  assign FILTER_SETTLED_FLAG  = settled_ff;

  // Helper counters for the checks below
  logic [SETTLE_W-1:0] chk_cyc_ff, nxt_chk_cyc;
  logic [2:0]          chk_n1_ff, nxt_chk_n1;
  logic [5:0]          chk_n2_ff, nxt_chk_n2;
  logic [1:0]          chk_n3_ff, nxt_chk_n3;
  logic [5:0]          chk_ratio2;

  always_comb begin
    chk_ratio2  = 6'h1 << log2_stage2;
    nxt_chk_cyc = (chk_cyc_ff == {SETTLE_W{1'b1}}) ? chk_cyc_ff : chk_cyc_ff + SETTLE_W'(1);
    nxt_chk_n1  = s1.valid ? 3'h0 : chk_n1_ff + {2'h0, s0.valid};
    nxt_chk_n2  = s2.valid ? 6'h0 : chk_n2_ff + {5'h0, s1.valid};
    nxt_chk_n3  = s3.valid ? 2'h0 : chk_n3_ff + {1'b0, s2.valid};
    if (restart_ff) begin
      nxt_chk_cyc = '0;
      nxt_chk_n1  = 3'h0;
      nxt_chk_n2  = 6'h0;
      nxt_chk_n3  = 2'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      chk_cyc_ff <= '0;
      chk_n1_ff  <= 3'h0;
      chk_n2_ff  <= 6'h0;
      chk_n3_ff  <= 2'h0;
    end else begin
      chk_cyc_ff <= nxt_chk_cyc;
      chk_n1_ff  <= nxt_chk_n1;
      chk_n2_ff  <= nxt_chk_n2;
      chk_n3_ff  <= nxt_chk_n3;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence normal_tick_s;
    tick_ff && !lp_mode_ff && !restart_ff;
  endsequence
  sequence low_tick_s;
    tick_ff && lp_mode_ff && !restart_ff;
  endsequence
  sequence low_quiet_s;
    low_tick_s ##1 (!tick_ff && !restart_ff) [*3];
  endsequence

  chk_normal_half_rate: assert property (
    normal_tick_s |=> !tick_ff ##1 (tick_ff || $past(restart_ff)))
    else $error("normal power tick not every second cycle");
  chk_low_gap_ticks: assert property (
    low_tick_s |=> (!tick_ff) [*3])
    else $error("low power tick came too early");
  chk_low_quarter_rate: assert property (
    low_quiet_s |=> tick_ff)
    else $error("low power tick not every fourth cycle");
  chk_stage1_four: assert property (
    s1.valid |-> chk_n1_ff == 3'h4)
    else $error("first stage did not take four words");
  chk_stage2_ratio: assert property (
    s2.valid |-> chk_n2_ff == chk_ratio2)
    else $error("second stage ratio wrong");
  chk_stage3_two: assert property (
    s3.valid |-> chk_n3_ff == 2'h2)
    else $error("third stage did not take two words");
  chk_settle_exact: assert property (
    $rose(settled_ff) |-> chk_cyc_ff == settle_target)
    else $error("settled flag rose at wrong count");
  chk_settle_never_early: assert property (
    settled_ff |-> chk_cyc_ff >= settle_target)
    else $error("settled flag high before settle count");
  chk_restart_clears: assert property (
    restart_ff |=> !FILTER_SETTLED_FLAG && !OUT_VALID && !INTERNAL_SAMPLE_TICK)
    else $error("restart did not clear flag and outputs");
  chk_word_passes: assert property (
    (s3.valid && settled_ff && !restart_ff) |=> OUT_VALID && OUT_WORD == $past(s3.data))
    else $error("settled output word dropped or altered");
  chk_reset_clears: assert property (
    disable iff (1'b0) !RST_N |=> !FILTER_SETTLED_FLAG && !OUT_VALID)
    else $error("reset did not clear outputs");

endmodule
`default_nettype wire

// File: dv/mod_source.sv
// Purpose: Modulator word source standing in front of the decimation chain
// Assumes: The chain samples MOD_WORD only in cycles where its sample tick is high
// Notes:   Drives the inverse word outside tick cycles so that stray sampling shows up
`timescale 1ns/1ps
`default_nettype none

module mod_source (
  input  wire logic                            tick,
  input  wire logic [sd_decim_pkg::WORD_W-1:0] level,
  output logic      [sd_decim_pkg::WORD_W-1:0] word
);
  import sd_decim_pkg::*;

  // One word per internal sample clock, the inverted word in between
  assign word = tick ? level : ~level;
endmodule

`default_nettype wire

// File: dv/tb.sv
// Purpose: Self-checking bench for the sigma-delta decimation chain
// Assumes: Shortened settle counts; inputs change 1 ns after the rising edge
// Notes:   A constant modulator word must come out unchanged from all-ones taps
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sd_decim_pkg::*;

  localparam int S64  = 40;
  localparam int S128 = 60;
  localparam int S256 = 80;

  logic              clk_sys;
  logic              rst_n;
  logic              sync_n;
  logic [1:0]        dec_sel;
  logic              low_power;
  logic [WORD_W-1:0] level;
  logic [WORD_W-1:0] mod_word;
  logic              tick;
  logic [WORD_W-1:0] out_word;
  logic              out_valid;
  logic              settled;
  int                num_errors;
  int                n_checks;

  // Chain under test with short settle counts
  sd_decim_chain #(
    .SETTLE_64  (SETTLE_W'(S64)),
    .SETTLE_128 (SETTLE_W'(S128)),
    .SETTLE_256 (SETTLE_W'(S256))
  ) uut (
    .CLK_SYS              (clk_sys),
    .RST_N                (rst_n),
    .SYNC_N               (sync_n),
    .DECIMATION_SELECT    (dec_sel),
    .LOW_POWER            (low_power),
    .MOD_WORD             (mod_word),
    .INTERNAL_SAMPLE_TICK (tick),
    .OUT_WORD             (out_word),
    .OUT_VALID            (out_valid),
    .FILTER_SETTLED_FLAG  (settled)
  );

  // Modulator in front of the chain
  mod_source src (
    .tick  (tick),
    .level (level),
    .word  (mod_word)
  );

  // 100 MHz master clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare tasks, one per kind of result
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
                          input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // One clock, then let the edge's updates land
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  // Follow one restart: settle moment, tick spacing, word spacing and value
  task automatic measure(input int ratio, input int period, input int nset, input int first_t);
    int t;
    int last_tick;
    int last_valid;
    int n_valid;
    t = 0;
    last_tick = 0;
    last_valid = 0;
    n_valid = 0;
    while (n_valid < 3) begin
      step();
      t++;
      if (t == 4) begin
        sync_n = 1'b1;
      end
      if (t >= first_t - nset && t < first_t) begin
        chk_bit(settled, 1'b0, "flag set early");
        chk_bit(out_valid, 1'b0, "word before settle");
      end
      if (t == first_t) begin
        chk_bit(settled, 1'b1, "flag not set");
      end
      if (tick === 1'b1 && t > first_t) begin
        if (last_tick > 0) chk_num(t - last_tick, period, "tick gap");
        last_tick = t;
      end
      if (out_valid === 1'b1) begin
        chk_word(out_word, level, "word value");
        if (last_valid > 0) chk_num(t - last_valid, ratio * period, "word gap");
        last_valid = t;
        n_valid++;
      end
      if (t > 4000) begin
        num_errors++;
        $display("[ERR] %0t no output words", $time);
        report_and_stop();
      end
    end
  endtask

  // Sync restart with a select code, power mode and input level
  task automatic sync_run(input logic [1:0] code, input logic lp, input logic [WORD_W-1:0] val,
                          input int ratio, input int nset);
    dec_sel = code;
    low_power = lp;
    level = val;
    repeat (5) step();
    sync_n = 1'b0;
    measure(ratio, lp ? 4 : 2, nset, nset + 4);
  endtask

  // Outputs stay low in reset; release acts as a restart in 64x
  task automatic sc_reset_release();
    chk_bit(tick, 1'b0, "tick in reset");
    chk_bit(out_valid, 1'b0, "valid in reset");
    chk_bit(settled, 1'b0, "flag in reset");
    chk_word(out_word, '0, "word in reset");
    rst_n = 1'b1;
    measure(64, 2, S64, S64 + 2);
  endtask

  // Every select code, back to back, each sync cutting the last run short
  task automatic sc_ratios();
    sync_run(DEC_128, 1'b0, 24'hc0ffee, 128, S128);
    sync_run(DEC_256, 1'b0, 24'h7fffff, 256, S256);
    sync_run(DEC_64, 1'b0, 24'h800000, 64, S64);
    sync_run(2'h3, 1'b0, 24'h123456, 64, S64);
  endtask

  // Low power halves the sample clock again
  task automatic sc_low_power();
    sync_run(DEC_128, 1'b1, 24'h5a5a5a, 128, S128);
  endtask

  // Reset in mid-run clears everything and restarts in the new mode
  task automatic sc_reset_mid();
    dec_sel = DEC_256;
    low_power = 1'b0;
    level = 24'hf00d01;
    rst_n = 1'b0;
    repeat (4) step();
    chk_bit(tick, 1'b0, "tick in reset");
    chk_bit(settled, 1'b0, "flag in reset");
    chk_word(out_word, '0, "word in reset");
    rst_n = 1'b1;
    measure(256, 2, S256, S256 + 2);
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    sync_n = SYNC_IDLE;
    dec_sel = DEC_64;
    low_power = 1'b0;
    level = 24'h3a5c71;
    repeat (20) step();
    sc_reset_release();
    sc_ratios();
    sc_low_power();
    sc_reset_mid();
    report_and_stop();
  end
endmodule

`default_nettype wire
